// ### dsl_detector.sv
// Purpose: Digital signal-loss detector with alarm/interrupt registers on AXI4-Lite.
// Assumes: Slicer bit tick and pulse arrive as pins, slower than half of aclk.
// Notes:   Change-of-condition flags are cleared by writing one; set wins over clear.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns

module dsl_detector #(
   parameter int unsigned LOSS_BITS  = dsl_pkg::LOSS_BITS,
   parameter int unsigned WIN_BITS   = dsl_pkg::WIN_BITS,
   parameter int unsigned WIN_PULSES = dsl_pkg::WIN_PULSES,
   parameter int unsigned WIN_COUNT  = dsl_pkg::WIN_COUNT
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // Slicer and analog-side pins
   input  wire logic                        line_bit_tick,
   input  wire logic                        line_pulse,
   input  wire logic                        analog_signal_loss,
   input  wire logic                        lock_loss,
   input  wire logic                        fifo_limit_alarm,
   input  wire logic                        driver_monitor_output,
   // AXI4-Lite write address
   input  wire logic [dsl_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [dsl_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [dsl_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // AXI4-Lite read data
   output logic [dsl_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Status outputs
   output logic                             irq,
   output logic                             digital_signal_loss,
   output logic                             signal_loss
);

   localparam int unsigned SIL_W = $clog2(LOSS_BITS + 1);
   localparam int unsigned BIT_W = $clog2(WIN_BITS + 1);
   localparam int unsigned WIN_W = $clog2(WIN_COUNT + 1);
   localparam logic [SIL_W-1:0] SIL_LAST = SIL_W'(LOSS_BITS - 1);
   localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WIN_BITS - 1);
   localparam logic [BIT_W-1:0] PUL_MIN  = BIT_W'(WIN_PULSES);
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_COUNT - 1);

   // Map a byte address onto a register index; low two bits select nothing
   function automatic logic [13:0] reg_index(input logic [dsl_pkg::ADDR_W-1:0] a);
      reg_index = a[15:2];
   endfunction

   // Pin synchroniser: two flops per pin, a third on the tick for its rising edge
   logic [dsl_pkg::PIN_N-1:0] pin_raw;
   logic [dsl_pkg::PIN_N-1:0] sync1_q;
   logic [dsl_pkg::PIN_N-1:0] sync2_q;
   logic                      tick3_q;

   assign pin_raw[dsl_pkg::PIN_TICK]  = line_bit_tick;
   assign pin_raw[dsl_pkg::PIN_PULSE] = line_pulse;
   assign pin_raw[dsl_pkg::PIN_ANALOG_SIGNAL_LOSS]  = analog_signal_loss;
   assign pin_raw[dsl_pkg::PIN_LOL]   = lock_loss;
   assign pin_raw[dsl_pkg::PIN_FL]    = fifo_limit_alarm;
   assign pin_raw[dsl_pkg::PIN_DMO]   = driver_monitor_output;

   // Only the second stage is read by logic; the first stage may be metastable.
   // One process for all pins, so every flop has a single driver.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         tick3_q <= 1'b0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         tick3_q <= sync2_q[dsl_pkg::PIN_TICK];
      end
   end

   // One bit period per rising edge of the slicer tick; pulse is sampled with it
   wire bit_stb   = sync2_q[dsl_pkg::PIN_TICK] & ~tick3_q;
   wire bit_pulse = sync2_q[dsl_pkg::PIN_PULSE];

   // Register state
   logic [dsl_pkg::REG_W-1:0] ctl_q;
   logic [dsl_pkg::REG_W-1:0] int_q;
   logic [dsl_pkg::REG_W-1:0] mask_q;
   logic [dsl_pkg::REG_W-1:0] int_d;

   wire digital_signal_loss_dis = ctl_q[dsl_pkg::CTL_DIGITAL_SIGNAL_LOSS_DIS];
   wire analog_signal_loss_dis = ctl_q[dsl_pkg::CTL_ANALOG_SIGNAL_LOSS_DIS];
   wire analog_signal_loss_now = sync2_q[dsl_pkg::PIN_ANALOG_SIGNAL_LOSS] & ~analog_signal_loss_dis;

   // Digital detector
   dsl_pkg::dsl_state_e st_q;
   dsl_pkg::dsl_state_e st_d;
   logic [SIL_W-1:0] sil_q;
   logic [SIL_W-1:0] sil_d;
   logic [BIT_W-1:0] bit_q;
   logic [BIT_W-1:0] bit_d;
   logic [BIT_W-1:0] pul_q;
   logic [BIT_W-1:0] pul_d;
   logic [WIN_W-1:0] win_q;
   logic [WIN_W-1:0] win_d;

   // Pulses counted in the window including the current bit
   wire [BIT_W-1:0] pul_now  = pul_q + BIT_W'(bit_pulse);
   wire             win_end  = bit_stb & (bit_q == BIT_LAST);
   wire             win_good = pul_now >= PUL_MIN;

   // Next-state logic: silence counting while watching, window grading while lost
   always_comb begin
      st_d  = st_q;
      sil_d = sil_q;
      bit_d = bit_q;
      pul_d = pul_q;
      win_d = win_q;
      case (st_q)
         dsl_pkg::DSL_WATCH: begin
            if (bit_stb) begin
               if (bit_pulse) begin
                  sil_d = '0;
               end else if (sil_q == SIL_LAST) begin
                  st_d  = dsl_pkg::DSL_LOST;
                  sil_d = '0;
                  bit_d = '0;
                  pul_d = '0;
                  win_d = '0;
               end else begin
                  sil_d = sil_q + SIL_W'(1);
               end
            end
         end
         dsl_pkg::DSL_LOST: begin
            if (win_end) begin
               bit_d = '0;
               pul_d = '0;
               if (!win_good) begin
                  win_d = '0;
               end else if (win_q == WIN_LAST) begin
                  st_d  = dsl_pkg::DSL_WATCH;
                  win_d = '0;
               end else begin
                  win_d = win_q + WIN_W'(1);
               end
            end else if (bit_stb) begin
               bit_d = bit_q + BIT_W'(1);
               pul_d = pul_now;
            end
         end
         default: begin
            st_d  = dsl_pkg::DSL_WATCH;
            sil_d = '0;
            bit_d = '0;
            pul_d = '0;
            win_d = '0;
         end
      endcase
      // A disabled detector holds no defect and restarts from silence zero
      if (digital_signal_loss_dis) begin
         st_d  = dsl_pkg::DSL_WATCH;
         sil_d = '0;
         bit_d = '0;
         pul_d = '0;
         win_d = '0;
      end
   end

   // Detector registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q  <= dsl_pkg::DSL_WATCH;
         sil_q <= '0;
         bit_q <= '0;
         pul_q <= '0;
         win_q <= '0;
      end else begin
         st_q  <= st_d;
         sil_q <= sil_d;
         bit_q <= bit_d;
         pul_q <= pul_d;
         win_q <= win_d;
      end
   end

   // Digital flag clears with the state, combined flag is the OR with analog
   wire digital_signal_loss_now = (st_q == dsl_pkg::DSL_LOST);
   wire los_now  = digital_signal_loss_now | analog_signal_loss_now;

   // Alarm status and change-of-condition events
   logic [dsl_pkg::REG_W-1:0] alarm_q;
   logic [dsl_pkg::REG_W-1:0] alarm_d;

   always_comb begin
      alarm_d                   = '0;
      alarm_d[dsl_pkg::ALM_DMO]  = sync2_q[dsl_pkg::PIN_DMO];
      alarm_d[dsl_pkg::ALM_LOS]  = los_now;
      alarm_d[dsl_pkg::ALM_LOL]  = sync2_q[dsl_pkg::PIN_LOL];
      alarm_d[dsl_pkg::ALM_FL]   = sync2_q[dsl_pkg::PIN_FL];
      alarm_d[dsl_pkg::ALM_ANALOG_SIGNAL_LOSS] = analog_signal_loss_now;
      alarm_d[dsl_pkg::ALM_DIGITAL_SIGNAL_LOSS] = digital_signal_loss_now;
   end

   // An event is a change between the stored alarm and its next value.
   // Signal loss tracks the combined state, so a digital clear under analog loss is silent.
   logic [dsl_pkg::REG_W-1:0] evt;
   always_comb begin
      evt                  = '0;
      evt[dsl_pkg::INT_DMO] = alarm_d[dsl_pkg::ALM_DMO] ^ alarm_q[dsl_pkg::ALM_DMO];
      evt[dsl_pkg::INT_LOS] = alarm_d[dsl_pkg::ALM_LOS] ^ alarm_q[dsl_pkg::ALM_LOS];
      evt[dsl_pkg::INT_LOL] = alarm_d[dsl_pkg::ALM_LOL] ^ alarm_q[dsl_pkg::ALM_LOL];
      evt[dsl_pkg::INT_FL]  = alarm_d[dsl_pkg::ALM_FL]  ^ alarm_q[dsl_pkg::ALM_FL];
   end

   // AXI4-Lite write path: address and data taken in either order
   logic                        aw_full_q;
   logic                        w_full_q;
   logic [dsl_pkg::ADDR_W-1:0]  awaddr_q;
   logic [dsl_pkg::REG_W-1:0]   wdata_q;
   logic                        wstrb0_q;

   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire aw_nxt   = (aw_full_q | aw_take) & ~do_write;
   wire w_nxt    = (w_full_q | w_take) & ~do_write;

   wire [13:0] widx   = reg_index(awaddr_q);
   wire        wr_ctl = do_write & wstrb0_q & (widx == dsl_pkg::IDX_RX_CONTROL);
   wire        wr_int = do_write & wstrb0_q & (widx == dsl_pkg::IDX_INT_STATUS);
   wire        wr_msk = do_write & wstrb0_q & (widx == dsl_pkg::IDX_INT_MASK);
   wire        w_hit  = (widx == dsl_pkg::IDX_RX_CONTROL) | (widx == dsl_pkg::IDX_INT_STATUS)
                      | (widx == dsl_pkg::IDX_INT_MASK) | (widx == dsl_pkg::IDX_ALARM_STATUS);

   // Write-one-to-clear, with a same-cycle event winning over the clear
   wire [dsl_pkg::REG_W-1:0] int_clr = wr_int ? (wdata_q & dsl_pkg::INT_WMASK) : '0;
   assign int_d = (int_q & ~int_clr) | evt;

   // Write channel handshake registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= dsl_pkg::RESP_OKAY;
      end else begin
         aw_full_q     <= aw_nxt;
         w_full_q      <= w_nxt;
         s_axi_awready <= ~aw_nxt;
         s_axi_wready  <= ~w_nxt;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? dsl_pkg::RESP_OKAY : dsl_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Captured write payloads; no reset needed, guarded by the full flags
   always_ff @(posedge aclk) begin
      if (aw_take) begin
         awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
         wdata_q  <= s_axi_wdata[dsl_pkg::REG_W-1:0];
         wstrb0_q <= s_axi_wstrb[0];
      end
   end

   // Register file updates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q   <= dsl_pkg::CTL_RESET;
         mask_q  <= dsl_pkg::MASK_RESET;
         int_q   <= '0;
         alarm_q <= '0;
      end else begin
         if (wr_ctl) begin
            ctl_q <= wdata_q & dsl_pkg::CTL_WMASK;
         end
         if (wr_msk) begin
            mask_q <= wdata_q & dsl_pkg::INT_WMASK;
         end
         int_q   <= int_d;
         alarm_q <= alarm_d;
      end
   end

   // AXI4-Lite read path: one read in flight, data registered
   wire        ar_take = s_axi_arvalid & s_axi_arready;
   wire        rv_nxt  = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [13:0] ridx    = reg_index(s_axi_araddr);

   wire r_int = (ridx == dsl_pkg::IDX_INT_STATUS);
   wire r_alm = (ridx == dsl_pkg::IDX_ALARM_STATUS);
   wire r_ctl = (ridx == dsl_pkg::IDX_RX_CONTROL);
   wire r_msk = (ridx == dsl_pkg::IDX_INT_MASK);
   wire r_hit = r_int | r_alm | r_ctl | r_msk;

   wire [dsl_pkg::REG_W-1:0] rsel = ({dsl_pkg::REG_W{r_int}} & int_q)
                                  | ({dsl_pkg::REG_W{r_alm}} & alarm_q)
                                  | ({dsl_pkg::REG_W{r_ctl}} & ctl_q)
                                  | ({dsl_pkg::REG_W{r_msk}} & mask_q);

   // Read channel registers; unmapped reads return zero with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= dsl_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~rv_nxt;
         s_axi_rvalid  <= rv_nxt;
         if (ar_take) begin
            s_axi_rdata <= {{(dsl_pkg::DATA_W - dsl_pkg::REG_W){1'b0}}, rsel};
            s_axi_rresp <= r_hit ? dsl_pkg::RESP_OKAY : dsl_pkg::RESP_SLVERR;
         end
      end
   end

   // Outputs: interrupt from the next status so it rises with the flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq                 <= 1'b0;
         digital_signal_loss <= 1'b0;
         signal_loss         <= 1'b0;
      end else begin
         irq                 <= |(int_d & mask_q);
         digital_signal_loss <= digital_signal_loss_now;
         signal_loss         <= los_now;
      end
   end

endmodule // dsl_detector

// ### dsl_detector_tb_top.sv
// Purpose: Self-checking bench for the digital signal-loss detector.
// Assumes: The slicer model gives one bit period every four aclk cycles.
// Notes:   Pulse patterns repeat every 32 bits, so any window holds the set density.
`timescale 1ns/1ns
module dsl_detector_tb_top;
   localparam logic [15:0] A_INT = {dsl_pkg::IDX_INT_STATUS, 2'b00};
   localparam logic [15:0] A_ALM = {dsl_pkg::IDX_ALARM_STATUS, 2'b00};
   localparam logic [15:0] A_CTL = {dsl_pkg::IDX_RX_CONTROL, 2'b00};
   localparam logic [15:0] A_MSK = {dsl_pkg::IDX_INT_MASK, 2'b00};
   logic        aclk = 1'b0, aresetn = 1'b0, ana = 1'b0;
   logic [3:0]  cond = 4'h0;
   logic [5:0]  density = 6'h20;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, dig, comb, tick, pulse;
   logic [1:0]  bresp, rresp, rs;
   int          errors = 0, check_count = 0, slot[3] = '{0, 2, 3};
   dsl_detector i_dut (.aclk(aclk), .aresetn(aresetn), .line_bit_tick(tick),
      .line_pulse(pulse), .analog_signal_loss(ana), .lock_loss(cond[2]),
      .fifo_limit_alarm(cond[3]), .driver_monitor_output(cond[0]), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
      .digital_signal_loss(dig), .signal_loss(comb));
   dsl_slicer_model i_slicer (.aclk(aclk), .density(density), .line_bit_tick(tick),
      .line_pulse(pulse));
   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   function automatic logic [31:0] alarm_exp(input logic d, input logic a);
      alarm_exp = {26'h0, d, a, cond[3], cond[2], d | a, cond[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Master side: both channels offered at once, each dropped when taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bit aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready) aw_ok = 1'b1;
         if (awready) awvalid <= 1'b0;
         if (wready) w_ok = 1'b1;
         if (wready) wvalid <= 1'b0;
      end
      repeat ($urandom_range(4)) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      repeat ($urandom_range(2)) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic expect_reg(input logic [15:0] a, input logic [31:0] exp);
      rd_reg(a);
      check(rd, exp);
   endtask
   task automatic bits(input int n);
      repeat (4 * n) @(posedge aclk);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog sized well above the roughly 9000 cycles the tests take
   initial begin
      #400000;
      errors++;
      report_and_stop();
   end
   initial begin
      void'($urandom(87726));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      expect_reg(A_CTL, 32'h01);
      expect_reg(A_INT, 32'h00);
      expect_reg(A_MSK, 32'h00);
      // Alarm writes are ignored, unmapped places are refused
      wr(A_ALM, 32'hff);
      check({30'h0, rs}, {30'h0, dsl_pkg::RESP_OKAY});
      expect_reg(A_ALM, 32'h00);
      wr(16'h0100, 32'h01);
      check({30'h0, rs}, {30'h0, dsl_pkg::RESP_SLVERR});
      rd_reg(16'h0100);
      check({rd[29:0], rs}, {30'h0, dsl_pkg::RESP_SLVERR});
      wr(A_MSK, 32'h0f);
      // Each other condition sets only its own change bit
      foreach (slot[i]) begin
         cond[slot[i]] <= 1'b1;
         repeat (8 + $urandom_range(7)) @(posedge aclk);
         check({31'h0, irq}, 32'h1);
         expect_reg(A_INT, 32'h1 << slot[i]);
         expect_reg(A_ALM, alarm_exp(1'b0, 1'b0));
         wr(A_INT, 32'h1 << slot[i]);
         expect_reg(A_INT, 32'h0);
         check({31'h0, irq}, 32'h0);
         cond[slot[i]] <= 1'b0;
         repeat (8) @(posedge aclk);
         wr(A_INT, 32'h0f);
      end
      // Declare, hold under nine pulses, clear at ten and at a random density
      for (int k = 0; k < 2; k++) begin
         density <= 6'h00;
         bits(130); // The old pattern may already have left 22 quiet bits
         check({31'h0, dig}, 32'h0);
         bits(40);
         check({30'h0, comb, dig}, 32'h3);
         expect_reg(A_ALM, alarm_exp(1'b1, 1'b0));
         expect_reg(A_INT, 32'h02);
         check({31'h0, irq}, 32'h1);
         wr(A_INT, 32'h02);
         density <= 6'h09;
         bits(400);
         check({31'h0, dig}, 32'h1);
         density <= (k == 0) ? 6'h0a : 6'h0b + 6'($urandom_range(21));
         bits(120);
         check({31'h0, dig}, 32'h1);
         bits(110);
         check({30'h0, comb, dig}, 32'h0);
         expect_reg(A_ALM, alarm_exp(1'b0, 1'b0));
         expect_reg(A_INT, 32'h02);
         wr(A_INT, 32'h02);
      end
      // Analog loss: masked, then unmasked; digital clearance under it is silent
      density <= 6'h20;
      wr(A_MSK, 32'h0d);
      ana <= 1'b1;
      bits(4);
      check({30'h0, comb, irq}, 32'h2);
      wr(A_MSK, 32'h0f);
      bits(1);
      check({31'h0, irq}, 32'h1);
      density <= 6'h00;
      bits(170);
      wr(A_INT, 32'h02);
      density <= 6'h20;
      bits(230);
      expect_reg(A_ALM, alarm_exp(1'b0, 1'b1));
      expect_reg(A_INT, 32'h00);
      ana <= 1'b0;
      bits(4);
      expect_reg(A_INT, 32'h02);
      wr(A_INT, 32'h02);
      // Both detectors disabled: long silence and analog loss stay quiet
      wr(A_CTL, 32'h31);
      expect_reg(A_CTL, 32'h31);
      density <= 6'h00;
      ana <= 1'b1;
      bits(200);
      check({30'h0, comb, dig}, 32'h0);
      expect_reg(A_ALM, alarm_exp(1'b0, 1'b0));
      expect_reg(A_INT, 32'h00);
      density <= 6'h20;
      ana <= 1'b0;
      bits(4);
      wr(A_CTL, 32'h01);
      report_and_stop();
   end
endmodule // dsl_detector_tb_top

// ### dsl_monitor.sv
// Purpose: Port-level checks of the signal-loss detector.
// Assumes: One aclk domain; tick and pulse pins are watched before the sync stage.
// Notes:   Raw counts lead the design by the sync delay, so limits are lower bounds.
`timescale 1ns/1ns
module dsl_monitor #(
   parameter int unsigned LOSS_BITS  = dsl_pkg::LOSS_BITS,
   parameter int unsigned WIN_BITS   = dsl_pkg::WIN_BITS,
   parameter int unsigned WIN_PULSES = dsl_pkg::WIN_PULSES,
   parameter int unsigned WIN_COUNT  = dsl_pkg::WIN_COUNT
) (
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic                       line_bit_tick,
   input wire logic                       line_pulse,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic [dsl_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic                       irq,
   input wire logic                       digital_signal_loss,
   input wire logic                       signal_loss
);
   logic       tick_q;
   logic [8:0] quiet_q;
   logic [8:0] span_q;
   logic [8:0] dense_q;
   wire        tick_rise = line_bit_tick & ~tick_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Quiet bits since the last pulse; bits and pulses while loss is declared
   always_ff @(posedge aclk) begin
      tick_q <= aresetn & line_bit_tick;
      if (!aresetn || (tick_rise && line_pulse)) quiet_q <= 9'h000;
      else if (tick_rise && quiet_q != 9'h1ff) quiet_q <= quiet_q + 9'h001;
      if (!aresetn || !digital_signal_loss) span_q <= 9'h000;
      else if (tick_rise && span_q != 9'h1ff) span_q <= span_q + 9'h001;
      if (!aresetn || !digital_signal_loss) dense_q <= 9'h000;
      else if (tick_rise && line_pulse && dense_q != 9'h1ff) dense_q <= dense_q + 9'h001;
   end
   property p_declare_quiet; $rose(digital_signal_loss) |-> quiet_q >= LOSS_BITS; endproperty
   a_declare_quiet: assert property (p_declare_quiet) else $error("loss declared early");
   property p_combined; digital_signal_loss |-> ##[0:1] signal_loss; endproperty
   a_combined: assert property (p_combined) else $error("combined flag missing");
   // One bit of slack: the first counted tick may fall just before the flag shows
   property p_clear_dense;
      $fell(digital_signal_loss) |-> span_q >= WIN_BITS * WIN_COUNT - 1
         && dense_q >= WIN_PULSES * WIN_COUNT - 1;
   endproperty
   a_clear_dense: assert property (p_clear_dense) else $error("loss cleared early");
   property p_write_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_write_lat: assert property (p_write_lat) else $error("write answer late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_read_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_rdata_top; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rdata_top: assert property (p_rdata_top) else $error("read upper bits set");
   c_declare: cover property ($rose(digital_signal_loss));
   c_clear: cover property ($fell(digital_signal_loss));
   c_irq: cover property ($rose(irq));
endmodule // dsl_monitor
bind dsl_detector dsl_monitor #(.LOSS_BITS(LOSS_BITS), .WIN_BITS(WIN_BITS),
   .WIN_PULSES(WIN_PULSES), .WIN_COUNT(WIN_COUNT)) i_mon (.aclk, .aresetn,
   .line_bit_tick, .line_pulse, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .irq, .digital_signal_loss, .signal_loss);

// ### dsl_pkg.sv
// Purpose: Shared constants for the digital signal-loss detector block.
// Assumes: AXI4-Lite register access, 32-bit data, one register per word.
// Notes:   Register offsets are word indices; byte address is four times the index.
package dsl_pkg;

   // Bus widths
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned REG_W       = 8;

   // Register indices, byte address = index * 4
   localparam logic [13:0] IDX_INT_STATUS   = 14'h1302; // line_interrupt_status
   localparam logic [13:0] IDX_ALARM_STATUS = 14'h1303; // line_alarm_status
   localparam logic [13:0] IDX_RX_CONTROL   = 14'h1305; // receive control
   localparam logic [13:0] IDX_INT_MASK     = 14'h1310; // interrupt mask

   // Alarm status field positions
   localparam int unsigned ALM_DMO     = 0;
   localparam int unsigned ALM_LOS     = 1;
   localparam int unsigned ALM_LOL     = 2;
   localparam int unsigned ALM_FL      = 3;
   localparam int unsigned ALM_ANALOG_SIGNAL_LOSS    = 4;
   localparam int unsigned ALM_DIGITAL_SIGNAL_LOSS    = 5;

   // Interrupt status field positions (change of condition)
   localparam int unsigned INT_DMO     = 0;
   localparam int unsigned INT_LOS     = 1;
   localparam int unsigned INT_LOL     = 2;
   localparam int unsigned INT_FL      = 3;

   // Receive control field positions
   localparam int unsigned CTL_EQ_EN   = 0;
   localparam int unsigned CTL_MON_EN  = 1;
   localparam int unsigned CTL_MUTE_EN = 2;
   localparam int unsigned CTL_ANALOG_SIGNAL_LOSS_DIS = 4;
   localparam int unsigned CTL_DIGITAL_SIGNAL_LOSS_DIS = 5;

   // Writable bits and reset values
   localparam logic [7:0] CTL_WMASK    = 8'h37;
   localparam logic [7:0] CTL_RESET    = 8'h01;
   localparam logic [7:0] INT_WMASK    = 8'h0f;
   localparam logic [7:0] MASK_RESET   = 8'h00;

   // Detector criteria
   localparam int unsigned LOSS_BITS   = 160; // silent bit periods to declare
   localparam int unsigned WIN_BITS    = 32;  // bit periods per clearance window
   localparam int unsigned WIN_PULSES  = 10;  // least pulses per window
   localparam int unsigned WIN_COUNT   = 5;   // consecutive good windows to clear

   // AXI responses
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // Pin input slots passed through the synchroniser
   localparam int unsigned PIN_TICK    = 0;
   localparam int unsigned PIN_PULSE   = 1;
   localparam int unsigned PIN_ANALOG_SIGNAL_LOSS    = 2;
   localparam int unsigned PIN_LOL     = 3;
   localparam int unsigned PIN_FL      = 4;
   localparam int unsigned PIN_DMO     = 5;
   localparam int unsigned PIN_N       = 6;

   // Detector states
   typedef enum logic [1:0] {
      DSL_WATCH = 2'b01,
      DSL_LOST  = 2'b10
   } dsl_state_e;

endpackage

// ### dsl_slicer_model.sv
// Purpose: Slicer stand-in giving bit ticks and line pulses.
// Assumes: One bit period is four aclk cycles, tick high for two.
// Notes:   Pulses fill the first density bits of every 32-bit run.
`timescale 1ns/1ns
module dsl_slicer_model (
   input  wire logic       aclk,
   input  wire logic [5:0] density,
   output logic            line_bit_tick = 1'b0,
   output logic            line_pulse = 1'b0
);
   logic [1:0] phase_q = 2'h0;
   logic [4:0] bit_q   = 5'h00;
   // Pulse moves only while the tick is low, so it is steady at each rise
   always @(posedge aclk) begin
      phase_q       <= phase_q + 2'h1;
      line_bit_tick <= (phase_q == 2'h3) || (phase_q == 2'h0);
      if (phase_q == 2'h1) begin
         bit_q      <= bit_q + 5'h01;
         line_pulse <= {1'b0, bit_q} < density;
      end
   end
endmodule // dsl_slicer_model
